// [core/token_net_host_registers.sv]
// host register bank, interrupt combining, RAM data port and probe of a token network node
`include "token_net_consts.svh"

module token_net_host_registers #(
	parameter int ADDR_W = 11
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst_b,
	input  wire token_net_pkg::bus_req_t     avs_req,
	input  wire logic [1:0]                  avs_byteenable,
	output logic [15:0]                      avs_readdata,
	output logic                             avs_waitrequest,
	input  wire token_net_pkg::core_events_t core_events,
	input  wire logic                        rx_inhibited_level,
	input  wire logic                        tx_free_level,
	input  wire logic                        probe_node_seen,
	input  wire logic [7:0]                  successor_id,
	output logic [7:0]                       probe_node_id,
	output logic [7:0]                       own_node_id,
	output logic                             irq,
	output logic [7:0]                       command_code,
	output logic                             command_strobe,
	output logic [ADDR_W-1:0]                ram_addr,
	output logic                             ram_we,
	output logic [15:0]                      ram_wdata,
	input  wire logic [15:0]                 ram_rdata,
	output logic                             dma_request
);
	import token_net_pkg::*;

	// the pointer carries eleven address bits at most
	if (ADDR_W < 9 || ADDR_W > 11) begin : g_bad_addr_w
		$error("ADDR_W must be 9 to 11");
	end

	logic [7:0]        irq_enable_mask;
	logic [7:0]        ram_pointer_high;
	logic [7:0]        ram_pointer_low;
	logic [15:0]       ram_data_port;
	logic [7:0]        operating_config;
	logic              upper_bank_select;
	logic [1:0]        bank_spare;
	logic [7:0]        first_setup;
	logic [7:0]        second_setup;
	logic [7:0]        host_bus_control;
	logic [7:0]        transfer_count;
	logic [7:0]        factory_test;
	logic              recon_flag;
	logic              too_many_nak_flag;
	logic              successor_changed_flag;
	logic              probe_flag;
	logic [7:0]        maskable_flags;
	logic [2:0]        sub_address;
	logic              wide_bus_select;
	logic              dma_request_enable;
	logic              dma_done_flag;
	bus_state_t        state;
	bus_state_t        next_state;
	logic              wr_hit;
	logic              rd_hit;
	logic [15:0]       next_readdata;
	logic [15:0]       ram_word;
	logic              swap_on;

	assign sub_address        = {upper_bank_select, operating_config[1:0]};
	assign wide_bus_select    = host_bus_control[`BIT_W16];
	assign dma_request_enable = ram_pointer_high[`BIT_DMA_REQUEST_ENABLE];
	assign dma_done_flag      = ~dma_request_enable;
	assign dma_request        = dma_request_enable;
	assign swap_on            = wide_bus_select & ram_pointer_low[0];

	// bus handshake: writes finish in one cycle, reads hold waitrequest for two cycles and answer in the third
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (avs_req.read)
					next_state = ST_FETCH;
			end
			ST_FETCH: begin
				next_state = ST_ANS;
			end
			ST_ANS: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	assign avs_waitrequest = (avs_req.read && state != ST_ANS);
	assign wr_hit          = avs_req.write && state == ST_IDLE && avs_byteenable[0];
	assign rd_hit          = avs_req.read && state == ST_ANS;

	// mask register, cleared by hardware reset
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			irq_enable_mask <= `RST_BYTE;
		else if (wr_hit && avs_req.address == `OFS_MASK)
			irq_enable_mask <= avs_req.writedata[7:0] & `FLAG_MASK;
	end

	// commands are passed on to the protocol engine as one-cycle strobes
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			command_code   <= `RST_BYTE;
			command_strobe <= 1'b0;
		end else begin
			command_strobe <= wr_hit && avs_req.address == `OFS_COMMAND;
			if (wr_hit && avs_req.address == `OFS_COMMAND)
				command_code <= avs_req.writedata[7:0];
		end
	end

	// pointer: address only takes effect on the low byte write
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			ram_pointer_high <= `RST_BYTE;
		else if (wr_hit && avs_req.address == `OFS_PTR_HIGH)
			ram_pointer_high <= avs_req.writedata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			ram_pointer_low <= `RST_BYTE;
		else if (wr_hit && avs_req.address == `OFS_PTR_LOW)
			ram_pointer_low <= avs_req.writedata[7:0];
	end

	// the step waits for the ram write strobe, so a written word lands at the old address
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ram_addr <= '0;
		end else if (wr_hit && avs_req.address == `OFS_PTR_LOW) begin
			ram_addr <= ADDR_W'({ram_pointer_high[2:0],
				avs_req.writedata[7:1], avs_req.writedata[0] & ~wide_bus_select});
		end else if (ram_pointer_high[`BIT_AUTOINC] &&
			(ram_we || (rd_hit && avs_req.address == `OFS_DATA))) begin
			ram_addr <= ram_addr + (wide_bus_select ? ADDR_W'(2) : ADDR_W'(1));
		end
	end

	// data port; a read preload happens at the low pointer write and, with auto-increment, after each data read
	assign ram_word = swap_on ? {ram_rdata[7:0], ram_rdata[15:8]} : ram_rdata;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ram_we    <= 1'b0;
			ram_wdata <= 16'h0000;
		end else begin
			ram_we <= wr_hit && avs_req.address == `OFS_DATA;
			if (wr_hit && avs_req.address == `OFS_DATA)
				ram_wdata <= swap_on ? {avs_req.writedata[7:0], avs_req.writedata[15:8]}
					: avs_req.writedata;
		end
	end

	logic preload_pending;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			preload_pending <= 1'b0;
			ram_data_port   <= 16'h0000;
		end else begin
			preload_pending <= (wr_hit && avs_req.address == `OFS_PTR_LOW
				&& ram_pointer_high[`BIT_RDDATA]) ||
				(rd_hit && avs_req.address == `OFS_DATA && ram_pointer_high[`BIT_AUTOINC]);
			if (preload_pending)
				ram_data_port <= ram_word;
		end
	end

	// config and bank select; a config write drops the upper bank bit
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			operating_config  <= `RST_CONFIG;
			upper_bank_select <= 1'b0;
			bank_spare        <= 2'b00;
		end else if (wr_hit && avs_req.address == `OFS_CONFIG) begin
			operating_config  <= avs_req.writedata[7:0];
			upper_bank_select <= 1'b0;
		end else if (wr_hit && avs_req.address == `OFS_BANK) begin
			operating_config[1:0] <= avs_req.writedata[1:0];
			upper_bank_select     <= avs_req.writedata[`BIT_SUB2];
			bank_spare            <= {avs_req.writedata[7], avs_req.writedata[3]};
		end
	end

	// address 7 bank; probe and node ID survive the soft reset bit
	logic bank_wr;

	assign bank_wr = wr_hit && avs_req.address == `OFS_BANKED;

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			probe_node_id <= `RST_BYTE;
		else if (bank_wr && sub_address == `SUB_PROBE)
			probe_node_id <= avs_req.writedata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			own_node_id <= `RST_BYTE;
		else if (bank_wr && sub_address == `SUB_NODE)
			own_node_id <= avs_req.writedata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			first_setup <= `RST_BYTE;
		else if (bank_wr && sub_address == `SUB_FIRST_SETUP)
			first_setup <= avs_req.writedata[7:0];
	end

	// the next-ID slot is read-only, so its writes land in the test byte
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			factory_test <= `RST_BYTE;
		else if (bank_wr && sub_address == `SUB_NEXT)
			factory_test <= avs_req.writedata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			second_setup <= `RST_BYTE;
		else if (bank_wr && sub_address == `SUB_SECOND_SETUP)
			second_setup <= avs_req.writedata[7:0];
	end

	// bit 7 switches the data port to sixteen bits
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			host_bus_control <= `RST_BYTE;
		else if (bank_wr && sub_address == `SUB_BUSCTL)
			host_bus_control <= avs_req.writedata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			transfer_count <= `RST_BYTE;
		else if (bank_wr && sub_address == `SUB_COUNT)
			transfer_count <= avs_req.writedata[7:0];
	end

	// sticky flags; a new event wins over a clear in the same cycle
	logic next_id_read;
	logic diag_read;
	logic clr_recon_cmd;
	logic clr_nak_cmd;
	logic soft_reset;

	assign next_id_read  = rd_hit && avs_req.address == `OFS_BANKED && sub_address == `SUB_NEXT;
	assign diag_read     = rd_hit && avs_req.address == `OFS_DIAG_RD;
	assign clr_recon_cmd = command_strobe &&
		(command_code == `CMD_CLR_RECON || command_code == `CMD_CLR_NAK);
	assign clr_nak_cmd   = command_strobe && command_code == `CMD_CLR_NAK;
	assign soft_reset    = operating_config[`BIT_CFG_RESET];

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			recon_flag <= 1'b0;
		else if (core_events.recon_flag)
			recon_flag <= 1'b1;
		else if (clr_recon_cmd || soft_reset)
			recon_flag <= 1'b0;
	end

	// only the power-on clear command reaches this one
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			too_many_nak_flag <= 1'b0;
		else if (core_events.too_many_nak_flag)
			too_many_nak_flag <= 1'b1;
		else if (clr_nak_cmd || soft_reset)
			too_many_nak_flag <= 1'b0;
	end

	// cleared by the read that hands the successor ID out
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			successor_changed_flag <= 1'b0;
		else if (core_events.successor_changed_flag)
			successor_changed_flag <= 1'b1;
		else if (next_id_read || soft_reset)
			successor_changed_flag <= 1'b0;
	end

	// successor is not probed; its ID comes from the next-ID register
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			probe_flag <= 1'b0;
		else if (probe_node_seen && probe_node_id != successor_id)
			probe_flag <= 1'b1;
		else if (diag_read || soft_reset)
			probe_flag <= 1'b0;
	end

	// rx inhibit and tx free are live levels, so masking only hides them
	always_comb begin
		maskable_flags                  = 8'h00;
		maskable_flags[`BIT_RXINH]      = rx_inhibited_level;
		maskable_flags[`BIT_DMADONE]    = dma_done_flag;
		maskable_flags[`BIT_NAK]        = too_many_nak_flag;
		maskable_flags[`BIT_RECON]      = recon_flag;
		maskable_flags[`BIT_SUCC]       = successor_changed_flag;
		maskable_flags[`BIT_TXFREE]     = tx_free_level;
	end

	// one gate per flag position; bits outside the six sources never pass
	localparam logic [7:0] IRQ_SOURCES = `FLAG_MASK;
	logic [7:0] gated_flags;

	for (genvar i = 0; i < 8; i++) begin : g_gate
		assign gated_flags[i] = maskable_flags[i] & irq_enable_mask[i] & IRQ_SOURCES[i];
	end

	// combinational so the line drops the cycle the last enabled flag clears
	assign irq = |gated_flags;

	// read mux
	always_comb begin
		next_readdata = 16'h0000;
		if (avs_req.address == `OFS_MASK)
			next_readdata = {8'h00, irq_enable_mask};
		else if (avs_req.address == `OFS_PTR_HIGH)
			next_readdata = {8'h00, ram_pointer_high};
		else if (avs_req.address == `OFS_PTR_LOW)
			next_readdata = {8'h00, ram_pointer_low};
		else if (avs_req.address == `OFS_DATA)
			next_readdata = wide_bus_select ? ram_data_port : {8'h00, ram_data_port[7:0]};
		else if (avs_req.address == `OFS_BANK)
			next_readdata = {8'h00, bank_spare[1], 3'b000, bank_spare[0],
				upper_bank_select, operating_config[1:0]};
		else if (avs_req.address == `OFS_CONFIG)
			next_readdata = {8'h00, operating_config};
		else if (avs_req.address == `OFS_BANKED) begin
			if (sub_address == `SUB_PROBE)
				next_readdata = {8'h00, probe_node_id};
			else if (sub_address == `SUB_NODE)
				next_readdata = {8'h00, own_node_id};
			else if (sub_address == `SUB_FIRST_SETUP)
				next_readdata = {8'h00, first_setup};
			else if (sub_address == `SUB_NEXT)
				next_readdata = {8'h00, successor_id};
			else if (sub_address == `SUB_SECOND_SETUP)
				next_readdata = {8'h00, second_setup};
			else if (sub_address == `SUB_BUSCTL)
				next_readdata = {8'h00, host_bus_control};
			else if (sub_address == `SUB_COUNT)
				next_readdata = {8'h00, transfer_count};
		end else if (avs_req.address == `OFS_STATUS_RD)
			next_readdata = {8'h00, maskable_flags};
		else if (avs_req.address == `OFS_DIAG_RD)
			next_readdata = {8'h00, 4'h0, too_many_nak_flag, probe_flag,
				successor_changed_flag, 1'b0};
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			avs_readdata <= 16'h0000;
		else if (state == ST_FETCH)
			avs_readdata <= next_readdata;
	end
endmodule : token_net_host_registers

// [core/token_net_consts.svh]
// register offsets, field positions and reset values of the token network host registers
// Operation
// - sixteen registers; undefined bits read unspecified, host writes them zero.
// - each mask bit sits at the position of the status bit it gates.
// - interrupt is OR of six flags each ANDed with its mask bit.
// - only the six listed flags can reach the interrupt output.
// - masking receive-inhibit or transmit-free hides it; unmasking shows it again if set.
// - clear flags command clears the reconfiguration timer interrupt.
// - only the power-on clear flags command clears the too-many-NAK interrupt.
// - reading the next-ID register clears the successor changed interrupt.
// - DMA done flag is inverse of DMA request enable; interrupts when DMA ends.
// - hardware reset loads the interrupt mask with all zeros.
// - data register is the port into RAM at the pointer address.
// - for reads, data register preloads from RAM on low pointer write and, with auto-increment, after each data read.
// - in wide bus mode pointer bit 0 selects byte swap of the 16-bit word.
// - seven registers share address 7, chosen by the sub-address bits.
// - host writes a probe ID; probe flag sets if that node is present.
// - probe cannot report the token successor; next-ID register gives it instead.
// - probe ID register clears to zero on hardware reset only.
// - host writes high pointer first; address loads on low pointer write.
// - upper bank at address 7 needs the extra bit; config write clears it.
`ifndef TOKEN_NET_CONSTS_SVH
`define TOKEN_NET_CONSTS_SVH

`define OFS_MASK        4'h0
`define OFS_COMMAND     4'h1
`define OFS_PTR_HIGH    4'h2
`define OFS_PTR_LOW     4'h3
`define OFS_DATA        4'h4
`define OFS_BANK        4'h5
`define OFS_CONFIG      4'h6
`define OFS_BANKED      4'h7
`define OFS_STATUS_RD   4'h8
`define OFS_DIAG_RD     4'h9

`define SUB_PROBE       3'h0
`define SUB_NODE        3'h1
`define SUB_FIRST_SETUP      3'h2
`define SUB_NEXT        3'h3
`define SUB_SECOND_SETUP      3'h4
`define SUB_BUSCTL      3'h5
`define SUB_COUNT       3'h6

`define BIT_RXINH       7
`define BIT_DMADONE     4
`define BIT_NAK         3
`define BIT_RECON       2
`define BIT_SUCC        1
`define BIT_TXFREE      0
`define BIT_PROBE       2
`define BIT_DMA_REQUEST_ENABLE       3
`define BIT_RDDATA      7
`define BIT_AUTOINC     6
`define BIT_W16         7
`define BIT_CFG_RESET   7
`define BIT_SUB2        2

`define CMD_CLEAR_FLAGS 4'h5
`define CMD_CLR_RECON   8'h0E
`define CMD_CLR_NAK     8'h16
`define RST_BYTE        8'h00
`define RST_CONFIG      8'h18
`define FLAG_MASK       8'h9F

`endif

// [core/token_net_pkg.sv]
// types shared by the token network host register block
package token_net_pkg;
	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [15:0] writedata;
	} bus_req_t;

	typedef struct packed {
		logic        rx_inhibited_flag;
		logic        tx_free_flag;
		logic        recon_flag;
		logic        successor_changed_flag;
		logic        too_many_nak_flag;
		logic        dma_finished;
	} core_events_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_ANS   = 2'b10
	} bus_state_t;
endpackage : token_net_pkg

// [test/token_ram_model.sv]
// behavioural packet RAM on the far side of the data port
module token_ram_model #(
	parameter int ADDR_W = 11
) (
	input  wire logic              clk_sys,
	input  wire logic [ADDR_W-1:0] ram_addr,
	input  wire logic              ram_we,
	input  wire logic [15:0]       ram_wdata,
	output logic [15:0]            ram_rdata,
	output logic [15:0]            last_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [2**ADDR_W];
	// unwritten words stay unknown so a stray preload never matches
	always_ff @(posedge clk_sys) begin
		if (ram_we) begin
			mem[ram_addr] <= ram_wdata;
			last_wdata <= ram_wdata;
		end
	end
	assign ram_rdata = mem[ram_addr];
endmodule : token_ram_model

// [test/token_net_host_registers_monitor.sv]
// assertion checker bound to the token network host register block
`include "token_net_consts.svh"
module token_net_host_registers_monitor #(
	parameter int ADDR_W = 11
) (
	input wire logic                    clk_sys,
	input wire logic                    rst_b,
	input wire token_net_pkg::bus_req_t avs_req,
	input wire logic [1:0]              avs_byteenable,
	input wire logic                    avs_waitrequest,
	input wire logic                    rx_inhibited_level,
	input wire logic                    tx_free_level,
	input wire logic                    irq,
	input wire logic [7:0]              command_code,
	input wire logic                    command_strobe,
	input wire logic [ADDR_W-1:0]       ram_addr,
	input wire logic                    ram_we,
	input wire logic                    dma_request
);
	timeunit 1ns;
	timeprecision 1ps;
	import token_net_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic       wr;
	logic [3:0] a;
	logic [7:0] d;
	logic [7:0] mask;
	assign wr = avs_req.write && avs_byteenable[0] && !avs_waitrequest;
	assign a = avs_req.address;
	assign d = avs_req.writedata[7:0];
	// shadow of the mask, so irq can be judged from the ports alone
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mask <= 8'h00;
		end else if (wr && a == `OFS_MASK) begin
			mask <= d;
		end
	end
	property p_quiet; mask == 8'h00 |-> !irq; endproperty
	a_quiet: assert property (p_quiet) else $error("irq with empty mask");
	property p_only; (mask & 8'h1E) == 8'h00 |->
		irq == ((mask[7] && rx_inhibited_level) || (mask[0] && tx_free_level)); endproperty
	a_only: assert property (p_only) else $error("irq not from masked levels");
	property p_dma; mask[`BIT_DMADONE] && !dma_request |-> irq; endproperty
	a_dma: assert property (p_dma) else $error("dma done not raising irq");
	property p_dreq; wr && a == `OFS_PTR_HIGH |=> dma_request == $past(d[`BIT_DMA_REQUEST_ENABLE]); endproperty
	a_dreq: assert property (p_dreq) else $error("dma request not loaded");
	property p_hold; wr && a == `OFS_PTR_HIGH |=> $stable(ram_addr); endproperty
	a_hold: assert property (p_hold) else $error("address moved on high write");
	property p_load; wr && a == `OFS_PTR_LOW |=> ram_addr[7:1] == $past(d[7:1]); endproperty
	a_load: assert property (p_load) else $error("address not loaded");
	property p_cmd; wr && a == `OFS_COMMAND |=> command_strobe && command_code == $past(d); endproperty
	a_cmd: assert property (p_cmd) else $error("command not issued");
	property p_rd; $rose(avs_req.read) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer timing");
	property p_we; wr && a == `OFS_DATA |=> ram_we; endproperty
	a_we: assert property (p_we) else $error("data write not passed to ram");
endmodule : token_net_host_registers_monitor

bind token_net_host_registers token_net_host_registers_monitor #(.ADDR_W(ADDR_W)) u_mon (
	.clk_sys, .rst_b, .avs_req, .avs_byteenable, .avs_waitrequest, .rx_inhibited_level,
	.tx_free_level, .irq, .command_code, .command_strobe, .ram_addr, .ram_we, .dma_request
);

// [test/tb_token_net_host_registers.sv]
// self-checking bench for the token network host register block
`include "token_net_consts.svh"
module tb_token_net_host_registers;
	timeunit 1ns;
	timeprecision 1ps;
	import token_net_pkg::*;
	logic         clk_sys = 1'h0;
	logic         rst_b = 1'h0;
	bus_req_t     avs_req = '0;
	logic [1:0]   avs_byteenable = 2'h3;
	logic [15:0]  avs_readdata, ram_wdata, ram_rdata, last_wdata, rd;
	logic         avs_waitrequest, irq, command_strobe, ram_we, dma_request;
	core_events_t core_events = '0;
	logic         rx_inhibited_level = 1'h0;
	logic         tx_free_level = 1'h0;
	logic         probe_node_seen = 1'h0;
	logic [7:0]   successor_id = 8'h5C;
	logic [7:0]   probe_node_id, own_node_id, command_code;
	logic [10:0]  ram_addr;
	int           bad_count = 0;
	int           checks = 0;
	token_net_host_registers #(.ADDR_W(11)) uut (
		.clk_sys, .rst_b, .avs_req, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.core_events, .rx_inhibited_level, .tx_free_level, .probe_node_seen,
		.successor_id, .probe_node_id, .own_node_id, .irq, .command_code,
		.command_strobe, .ram_addr, .ram_we, .ram_wdata, .ram_rdata, .dma_request
	);
	token_ram_model #(.ADDR_W(11)) u_ram (
		.clk_sys, .ram_addr, .ram_we, .ram_wdata, .ram_rdata, .last_wdata
	);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic r, input logic [3:0] a, input logic [15:0] d);
		int n;
		n = 0;
		avs_req <= '{read: r, write: !r, address: a, writedata: d};
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'h0 && n < 9) begin
			n++;
			@(posedge clk_sys);
		end
		chk("wait", 16'h0000, 16'(avs_waitrequest));
		rd = avs_readdata;
		avs_req <= '0;
		@(posedge clk_sys);
	endtask : bus
	task automatic pulse(input core_events_t e, input logic s);
		core_events <= e;
		probe_node_seen <= s;
		@(posedge clk_sys);
		core_events <= '0;
		probe_node_seen <= 1'h0;
		@(posedge clk_sys);
	endtask : pulse
	// ram latches one edge after the strobe, so wait before looking
	task automatic put(input logic [15:0] d, input logic [15:0] exp);
		bus(1'h0, `OFS_DATA, d);
		@(posedge clk_sys);
		chk("ram word", exp, last_wdata);
	endtask : put
	task automatic t_reset;
		chk("irq", 16'h0000, 16'(irq));
		chk("probe", 16'h0000, {8'h00, probe_node_id});
		bus(1'h1, 4'hC, 16'h0000);
		chk("unmapped", 16'h0000, rd);
		$display("test reset done");
	endtask : t_reset
	task automatic t_mask;
		logic [7:0] m [4] = '{8'h60, 8'h80, 8'h00, 8'h01};
		rx_inhibited_level <= 1'h1;
		tx_free_level <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			bus(1'h0, `OFS_MASK, {8'h00, m[i]});
			chk("irq", 16'(i[0]), 16'(irq));
		end
		bus(1'h1, `OFS_STATUS_RD, 16'h0000);
		chk("status", 16'h0091, rd);
		tx_free_level <= 1'h0;
		@(posedge clk_sys);
		chk("irq", 16'h0000, 16'(irq));
		rx_inhibited_level <= 1'h0;
		$display("test mask done");
	endtask : t_mask
	task automatic t_sticky;
		pulse(core_events_t'(6'h0E), 1'h0);
		bus(1'h1, `OFS_DIAG_RD, 16'h0000);
		chk("diag", 16'h000A, rd);
		bus(1'h0, `OFS_COMMAND, {8'h00, `CMD_CLR_RECON});
		bus(1'h0, `OFS_MASK, 16'h0004);
		chk("irq", 16'h0000, 16'(irq));
		bus(1'h0, `OFS_MASK, 16'h0008);
		chk("irq", 16'h0001, 16'(irq));
		bus(1'h0, `OFS_COMMAND, {8'h00, `CMD_CLR_NAK});
		repeat (2) @(posedge clk_sys);
		chk("irq", 16'h0000, 16'(irq));
		bus(1'h0, `OFS_MASK, 16'h0002);
		chk("irq", 16'h0001, 16'(irq));
		bus(1'h0, `OFS_BANK, {13'h0000, `SUB_NEXT});
		bus(1'h1, `OFS_BANKED, 16'h0000);
		chk("next id", {8'h00, successor_id}, {8'h00, rd[7:0]});
		@(posedge clk_sys);
		chk("irq", 16'h0000, 16'(irq));
		$display("test sticky done");
	endtask : t_sticky
	task automatic t_dma;
		bus(1'h0, `OFS_MASK, 16'h0010);
		chk("irq", 16'h0001, 16'(irq));
		bus(1'h0, `OFS_PTR_HIGH, 16'h0008);
		chk("irq", 16'h0000, 16'(irq));
		bus(1'h0, `OFS_MASK, 16'h0000);
		$display("test dma done");
	endtask : t_dma
	task automatic t_probe;
		bus(1'h0, `OFS_BANK, 16'h0000);
		bus(1'h0, `OFS_BANKED, 16'h002A);
		bus(1'h0, `OFS_BANK, {13'h0000, `SUB_NODE});
		bus(1'h0, `OFS_BANKED, 16'h0033);
		chk("node", 16'h0033, {8'h00, own_node_id});
		chk("probe", 16'h002A, {8'h00, probe_node_id});
		successor_id <= 8'h2A;
		pulse('0, 1'h1);
		bus(1'h1, `OFS_DIAG_RD, 16'h0000);
		chk("probe flag", 16'h0000, 16'(rd[`BIT_PROBE]));
		successor_id <= 8'h5C;
		pulse('0, 1'h1);
		bus(1'h1, `OFS_DIAG_RD, 16'h0000);
		chk("probe flag", 16'h0001, 16'(rd[`BIT_PROBE]));
		bus(1'h0, `OFS_CONFIG, 16'h0098);
		bus(1'h0, `OFS_CONFIG, 16'h0018);
		chk("probe", 16'h002A, {8'h00, probe_node_id});
		$display("test probe done");
	endtask : t_probe
	task automatic t_ram;
		bus(1'h0, `OFS_PTR_HIGH, 16'h0001);
		bus(1'h0, `OFS_PTR_LOW, 16'h0010);
		bus(1'h0, `OFS_DATA, 16'h00A5);
		@(posedge clk_sys);
		chk("ram byte", 16'h00A5, {8'h00, last_wdata[7:0]});
		bus(1'h0, `OFS_PTR_HIGH, 16'h0081);
		bus(1'h0, `OFS_PTR_LOW, 16'h0010);
		@(posedge clk_sys);
		bus(1'h1, `OFS_DATA, 16'h0000);
		chk("preload", 16'h00A5, {8'h00, rd[7:0]});
		bus(1'h0, `OFS_BANK, {13'h0000, `SUB_BUSCTL});
		bus(1'h0, `OFS_BANKED, 16'h0080);
		bus(1'h0, `OFS_PTR_LOW, 16'h0021);
		put(16'h1234, 16'h3412);
		bus(1'h0, `OFS_PTR_LOW, 16'h0020);
		put(16'h1234, 16'h1234);
		bus(1'h0, `OFS_CONFIG, 16'h0018);
		bus(1'h1, `OFS_BANK, 16'h0000);
		chk("bank", 16'h0000, {13'h0000, rd[2:0]});
		$display("test ram done");
	endtask : t_ram
	task automatic t_auto;
		bus(1'h0, `OFS_PTR_HIGH, 16'h0041);
		bus(1'h0, `OFS_PTR_LOW, 16'h0020);
		put(16'h1234, 16'h1234);
		put(16'hBEEF, 16'hBEEF);
		bus(1'h0, `OFS_PTR_HIGH, 16'h00C1);
		bus(1'h0, `OFS_PTR_LOW, 16'h0020);
		@(posedge clk_sys);
		bus(1'h1, `OFS_DATA, 16'h0000);
		chk("word 0", 16'h1234, rd);
		bus(1'h1, `OFS_DATA, 16'h0000);
		chk("word 1", 16'hBEEF, rd);
		$display("test auto done");
	endtask : t_auto
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	// the tests need a few hundred cycles; this allows five thousand
	initial begin
		#20000;
		bad_count++;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'h1;
		@(posedge clk_sys);
		t_reset;
		t_mask;
		t_sticky;
		t_dma;
		t_probe;
		t_ram;
		t_auto;
		complete_run;
	end
endmodule : tb_token_net_host_registers
